// File: pkg/poerb_cfg.svh
// poerb_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name; the clock runs at 125 MHz
`ifndef POERB_CFG_SVH
`define POERB_CFG_SVH

// ****************************************
// register codes (4-bit register select)
// ****************************************
`define POERB_REG_SUMMARY 4'h0
`define POERB_REG_COMMON 4'h1
`define POERB_REG_FUNC 4'h2
`define POERB_REG_PWR 4'h3
`define POERB_REG_STATUS 4'h4
`define POERB_REG_TEST 4'hf

// ****************************************
// field positions and writable masks
// ****************************************
`define POERB_CC_SWRST 0
`define POERB_CC_KILL 1
`define POERB_CC_UVOV_DIS 2
`define POERB_CC_AC_LO 3
`define POERB_CC_AC_HI 4
`define POERB_CC_TSD_DIS 5
`define POERB_CC_MASK 8'h3e
`define POERB_TR_ERR_DIS 1
`define POERB_TR_DCD_DIS 2
`define POERB_TR_POR_FORCE 3
`define POERB_TR_TMR_DIS 4
`define POERB_TR_HALT 5
`define POERB_TR_TSD 6
`define POERB_TR_MASK 8'h7e
`define POERB_F1_DFD 5
`define POERB_F1_DCM 4
`define POERB_F1_MASK 8'h3f
`define POERB_F2_CLASS_LIM 1
`define POERB_F2_ABORT 2
`define POERB_F2_ADC_GO 3
`define POERB_F2_OFF 4
`define POERB_F2_MASK 8'h16
`define POERB_RESET_VAL 8'h00

// ****************************************
// timing
// ****************************************
`define POERB_CLK_MHZ 125
`define POERB_DISC_TIME_US 4000
`define POERB_POR_TIME_US 1000
`define POERB_DISC_CYCLES (`POERB_DISC_TIME_US * `POERB_CLK_MHZ)
`define POERB_POR_CYCLES (`POERB_POR_TIME_US * `POERB_CLK_MHZ)

`endif

// File: pkg/poerb_pkg.sv
// poerb_pkg: types shared by the port manager register bank
// assumes: nothing beyond a SystemVerilog compiler
package poerb_pkg;

  // port function codes
  typedef enum logic [3:0] {
    FN_OFF = 4'h0,
    FN_DISC1 = 4'h1,
    FN_DISC2 = 4'h2,
    FN_VSAMPLE = 4'h3,
    FN_LEGACY = 4'h4,
    FN_CLASSIFY = 4'h5,
    FN_RAMP_UP = 4'h6,
    FN_CONT_SAMPLE = 4'h7,
    FN_RAMP_DOWN = 4'h8,
    FN_AC_LOW = 4'h9,
    FN_AC_HIGH = 4'ha,
    FN_ISAMPLE = 4'hb,
    FN_TSAMPLE = 4'hc
  } poerb_func_e;

  // current limit selection toward the port switch
  typedef enum logic [1:0] {
    ILIM_FULL = 2'h0,
    ILIM_CLASS1 = 2'h1,
    ILIM_CLASS2 = 2'h2
  } poerb_ilim_e;

  // codes 1101..1111 start nothing
  function automatic logic func_is_spare(input logic [3:0] code);
    func_is_spare = (code > 4'hc);
  endfunction : func_is_spare

  // either discovery phase
  function automatic logic func_is_disc(input logic [3:0] code);
    func_is_disc = (code == FN_DISC1) || (code == FN_DISC2);
  endfunction : func_is_disc

endpackage : poerb_pkg

// File: hw/poerb_por_timer.sv
// poerb_por_timer: power-on reset timing for the register bank
// assumes: supply_ok comes from a pin; soft_rst is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
`include "poerb_cfg.svh"
module poerb_por_timer #(
  parameter int POR_CYCLES = `POERB_POR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic supply_ok,
  input wire logic soft_rst,
  input wire logic force_ok,
  output logic por_ok
);
  localparam int CW = $clog2(POR_CYCLES + 1);

  // ****************************************
  // supply synchroniser and counter
  // ****************************************
  logic sup_s1; // first stage, read only by sup_s2
  logic sup_s2; // settled supply level
  logic [CW-1:0] por_cnt; // cycles since supply became valid
  logic por_done; // timer expired

  // two flops before any logic sees the supply level
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
    end else begin
      sup_s1 <= supply_ok;
      sup_s2 <= sup_s1;
    end
  end

  // a software reset restarts the whole timing cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn || !sup_s2 || soft_rst) begin
      por_cnt <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt <= por_cnt + CW'(1);
      por_done <= (por_cnt == CW'(POR_CYCLES - 1));
    end
  end

  // the test force bypasses the timer but not a cleared force bit
  assign por_ok = por_done | force_ok;

endmodule : poerb_por_timer

// File: hw/poerb_port_slice.sv
// poerb_port_slice: control and status registers of one power port
// assumes: write strobes already decoded for this port; inputs on ref_clk
`timescale 1ns/1ps
`include "poerb_cfg.svh"
module poerb_port_slice #(
  parameter int DISC_CYCLES = `POERB_DISC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic regs_rstn,
  input wire logic wr_func,
  input wire logic wr_pwr,
  input wire logic [7:0] wr_data,
  input wire logic disc_halt,
  input wire logic disc_timer_dis,
  input wire logic complete_in,
  input wire logic disc_fail_in,
  input wire logic [2:0] class_in,
  input wire logic [2:0] fault_in,
  output logic [3:0] func_code,
  output logic func_start,
  output logic disc_fault_dis,
  output logic disconnect_mask,
  output logic port_off,
  output logic adc_start,
  output logic adc_abort,
  output logic [1:0] ilim_sel,
  output logic [7:0] status
);
  localparam int CW = $clog2(DISC_CYCLES + 1);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] func_reg; // first control register, masked
  logic [7:0] pwr_reg; // second control register, masked
  logic done; // function complete flag
  logic [CW-1:0] disc_cnt; // discovery phase time left
  wire [3:0] wr_code = wr_data[3:0];
  wire disc_run = (disc_cnt != '0) && !disc_halt && !disc_timer_dis;
  wire disc_expire = disc_run && (disc_cnt == CW'(1));

  // control registers; spare bits never stored
  always_ff @(posedge ref_clk) begin
    if (!regs_rstn) begin
      func_reg <= `POERB_RESET_VAL;
      pwr_reg <= `POERB_RESET_VAL;
    end else begin
      if (wr_func) func_reg <= wr_data & `POERB_F1_MASK;
      if (wr_pwr) pwr_reg <= wr_data & `POERB_F2_MASK;
    end
  end

  // strobes: start only on a coded function, adc start self clears
  always_ff @(posedge ref_clk) begin
    if (!regs_rstn) begin
      func_start <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      func_start <= wr_func && !poerb_pkg::func_is_spare(wr_code);
      adc_start <= wr_pwr && wr_data[`POERB_F2_ADC_GO];
    end
  end

  // discovery phase timer; frozen while halted or disabled
  always_ff @(posedge ref_clk) begin
    if (!regs_rstn) begin
      disc_cnt <= '0;
    end else if (wr_func) begin
      disc_cnt <= poerb_pkg::func_is_disc(wr_code) ? CW'(DISC_CYCLES) : '0;
    end else if (disc_run) begin
      disc_cnt <= disc_cnt - CW'(1);
    end
  end

  // done flag: a completion in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!regs_rstn) begin
      done <= 1'b0;
    end else if (complete_in || disc_expire) begin
      done <= 1'b1;
    end else if (wr_func) begin
      done <= 1'b0;
    end
  end

  // class based current limit, registered toward the switch
  always_ff @(posedge ref_clk) begin
    if (!regs_rstn) begin
      ilim_sel <= poerb_pkg::ILIM_FULL;
    end else if (!pwr_reg[`POERB_F2_CLASS_LIM] || class_in > 3'h2 || class_in == 3'h0) begin
      ilim_sel <= poerb_pkg::ILIM_FULL;
    end else begin
      ilim_sel <= (class_in == 3'h1) ? poerb_pkg::ILIM_CLASS1 : poerb_pkg::ILIM_CLASS2;
    end
  end

  assign func_code = func_reg[3:0];
  assign disc_fault_dis = func_reg[`POERB_F1_DFD];
  assign disconnect_mask = func_reg[`POERB_F1_DCM];
  assign port_off = pwr_reg[`POERB_F2_OFF];
  assign adc_abort = pwr_reg[`POERB_F2_ABORT];
  assign status = {disc_fail_in, done, class_in, fault_in};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!regs_rstn);

  sequence s_go_pulse;
    adc_start ##1 !adc_start;
  endsequence
  a_adc_self_clear: assert property (
    (wr_pwr && wr_data[3] && !$past(wr_pwr)) |=> s_go_pulse)
    else $error("adc start not a single pulse");
  a_done_cleared: assert property (
    (wr_func && !complete_in && !disc_expire) |=> !status[6])
    else $error("function write did not clear done");
  a_done_set: assert property (
    complete_in |=> status[6])
    else $error("completion not flagged");
  a_ilim_class1: assert property (
    (pwr_reg[1] && class_in == 3'h1) |=> ilim_sel == 2'h1)
    else $error("class 1 limit not selected");
  a_ilim_full: assert property (
    !pwr_reg[1] |=> ilim_sel == 2'h0)
    else $error("full limit not selected");

endmodule : poerb_port_slice

// File: hw/poerb_top.sv
// poerb_top: register bank of a four-port power sourcing manager
// assumes: a serial host engine on ref_clk gives decoded register strobes;
// port state machines and measurement logic run on ref_clk too
//
// Summary of operation
// - summary bits 7..4 flag faults, ports 4..1
// - bits 3:2 revision, bits 1:0 identity, fixed
// - test bit 6 forces thermal shutdown
// - test bit 5 halts all discovery
// - test bit 4 stops 4 ms discovery timers
// - test bit 3 forces power-on reset done
// - test bit 2 disables 300 ms disconnect timer
// - test bit 1 disables 750 ms error timer
// - control bits 4/3 drive oscillator high/low
// - control bit 1 kills all ports, no ramp
// - control bit 0 resets, restarts reset timing
// - first port control replicated per port
// - port bit 5 disables discovery fault limits
// - port bit 4 masks disconnect detection
// - function codes 0000..0111 decoded as listed
// - codes 1000..1100 decoded, 1101..1111 spare
// - port control 2 bit 3 starts adc, self-clears
// - bit 1 picks class or full current limit
// - done flag set on completion, cleared by write
// - status bits 2:0 carry the fault code
// - port writes hit one port, common all
// - registers held reset until supply and timer, or test force
`timescale 1ns/1ps
`include "poerb_cfg.svh"
module poerb_top #(
  parameter int POR_CYCLES = `POERB_POR_CYCLES,
  parameter int DISC_CYCLES = `POERB_DISC_CYCLES,
  parameter logic [1:0] CHIP_REV = 2'h1, // arbitrary value
  parameter logic [1:0] CHIP_ID = 2'h3 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic supply_ok,
  input wire logic thermal_sense,
  input wire logic [3:0] reg_sel,
  input wire logic [1:0] port_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0] port_complete,
  input wire logic [3:0] port_disc_fail,
  input wire logic [3:0][2:0] port_class,
  input wire logic [3:0][2:0] port_fault,
  output logic regs_rstn,
  output logic thermal_shutdown,
  output logic ports_kill,
  output logic ac_hi_on,
  output logic ac_lo_on,
  output logic tsd_fault_dis,
  output logic supply_range_fault_dis,
  output logic disc_halt,
  output logic disc_timer_dis,
  output logic dc_disc_timer_dis,
  output logic err_timer_dis,
  output logic [3:0][3:0] func_code,
  output logic [3:0] func_start,
  output logic [3:0] disc_fault_dis,
  output logic [3:0] disconnect_mask,
  output logic [3:0] port_off,
  output logic [3:0] adc_start,
  output logic [3:0] adc_abort,
  output logic [3:0][1:0] ilim_sel
);

  // ****************************************
  // address decode
  // ****************************************
  logic por_ok; // reset timing finished or forced
  logic [7:0] common_reg; // common control, bit 0 never stored
  logic [7:0] test_reg; // test register
  logic [3:0][7:0] port_status; // per-port status bytes
  wire sel_summary = (reg_sel == `POERB_REG_SUMMARY);
  wire sel_status = (reg_sel == `POERB_REG_STATUS);
  // writes are refused while the bank is held in reset
  wire wr_ok = reg_wr && por_ok;
  wire wr_common = wr_ok && (reg_sel == `POERB_REG_COMMON);
  // the test register stays writable so the reset force can be set
  wire wr_test = reg_wr && (reg_sel == `POERB_REG_TEST);
  wire [3:0] port_hit = 4'h1 << port_sel;
  wire [3:0] wr_func = {4{wr_ok && (reg_sel == `POERB_REG_FUNC)}} & port_hit;
  wire [3:0] wr_pwr = {4{wr_ok && (reg_sel == `POERB_REG_PWR)}} & port_hit;
  wire soft_rst = wr_common && reg_wdata[`POERB_CC_SWRST];

  // ****************************************
  // reset timing
  // ****************************************
  // held in reset until supply valid and timer expired, or until the test force bit is set
  assign regs_rstn = resetn && por_ok;

  poerb_por_timer #(
    .POR_CYCLES(POR_CYCLES)
  ) u_por (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .supply_ok(supply_ok),
    .soft_rst(soft_rst),
    .force_ok(test_reg[`POERB_TR_POR_FORCE]),
    .por_ok(por_ok)
  );

  // ****************************************
  // common registers
  // ****************************************
  // common control; spare bits and the reset bit are never stored
  always_ff @(posedge ref_clk) begin
    if (!regs_rstn) begin
      common_reg <= `POERB_RESET_VAL;
    end else if (wr_common) begin
      common_reg <= reg_wdata & `POERB_CC_MASK;
    end
  end

  // test register; cleared by a software reset as well
  always_ff @(posedge ref_clk) begin
    if (!resetn || soft_rst) begin
      test_reg <= `POERB_RESET_VAL;
    end else if (wr_test) begin
      test_reg <= reg_wdata & `POERB_TR_MASK;
    end
  end

  assign ports_kill = common_reg[`POERB_CC_KILL];
  assign ac_hi_on = common_reg[`POERB_CC_AC_HI];
  assign ac_lo_on = common_reg[`POERB_CC_AC_LO];
  assign tsd_fault_dis = common_reg[`POERB_CC_TSD_DIS];
  assign supply_range_fault_dis = common_reg[`POERB_CC_UVOV_DIS];
  assign disc_halt = test_reg[`POERB_TR_HALT];
  assign disc_timer_dis = test_reg[`POERB_TR_TMR_DIS];
  assign dc_disc_timer_dis = test_reg[`POERB_TR_DCD_DIS];
  assign err_timer_dis = test_reg[`POERB_TR_ERR_DIS];

  // ****************************************
  // thermal shutdown
  // ****************************************
  logic ts_s1; // first stage, read only by ts_s2
  logic ts_s2; // settled thermal sense

  // pin crosses two flops before use
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ts_s1 <= 1'b0;
      ts_s2 <= 1'b0;
    end else begin
      ts_s1 <= thermal_sense;
      ts_s2 <= ts_s1;
    end
  end

  // real sense or test force, registered
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      thermal_shutdown <= 1'b0;
    end else begin
      thermal_shutdown <= ts_s2 || test_reg[`POERB_TR_TSD];
    end
  end

  // ****************************************
  // per-port registers
  // ****************************************
  for (genvar p = 0; p < 4; p++) begin : g_port
    poerb_port_slice #(
      .DISC_CYCLES(DISC_CYCLES)
    ) u_slice (
      .ref_clk(ref_clk),
      .regs_rstn(regs_rstn),
      .wr_func(wr_func[p]),
      .wr_pwr(wr_pwr[p]),
      .wr_data(reg_wdata),
      .disc_halt(disc_halt),
      .disc_timer_dis(disc_timer_dis),
      .complete_in(port_complete[p]),
      .disc_fail_in(port_disc_fail[p]),
      .class_in(port_class[p]),
      .fault_in(port_fault[p]),
      .func_code(func_code[p]),
      .func_start(func_start[p]),
      .disc_fault_dis(disc_fault_dis[p]),
      .disconnect_mask(disconnect_mask[p]),
      .port_off(port_off[p]),
      .adc_start(adc_start[p]),
      .adc_abort(adc_abort[p]),
      .ilim_sel(ilim_sel[p]),
      .status(port_status[p])
    );
  end

  // ****************************************
  // read path
  // ****************************************
  // general fault per port: any nonzero fault code
  wire [3:0] fault_flag = {|port_fault[3], |port_fault[2], |port_fault[1], |port_fault[0]};
  wire [7:0] summary_byte = {fault_flag, CHIP_REV, CHIP_ID};
  // write-only and unmapped codes read as zero
  wire [7:0] next_rdata = !por_ok ? 8'h00 :
                          sel_summary ? summary_byte :
                          sel_status ? port_status[port_sel] : 8'h00;

  // read data from a flop, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_rd_summary;
    reg_rd && sel_summary && por_ok;
  endsequence
  a_fault_summary: assert property (
    s_rd_summary |=> reg_rdata[7:4] == $past(fault_flag))
    else $error("fault summary bits wrong");
  a_chip_ident: assert property (
    s_rd_summary |=> reg_rdata[3:0] == {CHIP_REV, CHIP_ID})
    else $error("revision or identity wrong");
  a_tsd_force: assert property (
    test_reg[6] |=> thermal_shutdown)
    else $error("forced thermal shutdown missing");
  a_kill_follow: assert property (
    (wr_common && reg_wdata[1] && !reg_wdata[0]) |=> ports_kill)
    else $error("all-port shutdown not applied");
  a_ac_drive: assert property (
    (wr_common && !reg_wdata[0]) |=> (ac_hi_on == $past(reg_wdata[4]))
      && (ac_lo_on == $past(reg_wdata[3])))
    else $error("oscillator drivers wrong");
  a_soft_restart: assert property (
    soft_rst |=> !por_ok && test_reg == 8'h00)
    else $error("software reset did not restart timing");
  a_held_reset: assert property (
    !por_ok |=> common_reg == 8'h00)
    else $error("registers not held in reset");
  a_held_read: assert property (
    (reg_rd && !por_ok) |=> reg_rdata == 8'h00)
    else $error("read while held in reset not zero");
  a_port_local: assert property (
    wr_func[0] |=> $stable(func_code[1]))
    else $error("write leaked to another port");
  a_wo_zero: assert property (
    (reg_rd && !sel_summary && !sel_status) |=> reg_rdata == 8'h00)
    else $error("write-only register read nonzero");
  a_test_bits: assert property (
    wr_test |=> dc_disc_timer_dis == $past(reg_wdata[2])
      && err_timer_dis == $past(reg_wdata[1]))
    else $error("timer disable bits wrong");

endmodule : poerb_top

// File: tb/poerb_port_model.sv
// poerb_port_model: stand-in for the per-port function state machines
// assumes: func_start and func_code come from the bank on ref_clk
`timescale 1ns/1ps
module poerb_port_model (
  input wire logic ref_clk,
  input wire logic [3:0] func_start,
  input wire logic [3:0][3:0] func_code,
  input wire logic [3:0] lat,
  output logic [3:0] port_complete
);
  // ****************
  // completion pulses
  // ****************
  logic [3:0][4:0] left = 20'h00000; // cycles to completion, 0 = idle
  logic [3:0] pulse = 4'h0; // one-cycle completion per port
  assign port_complete = pulse;
  // discovery ends by the bank's own timer, so it gets no answer here
  always_ff @(posedge ref_clk) begin
    for (int p = 0; p < 4; p++) begin
      pulse[p] <= (left[p] == 5'h01);
      if (func_start[p] && !(func_code[p] inside {4'h1, 4'h2})) begin
        left[p] <= {1'h0, lat} + 5'h01; // lat 0 prompt, 15 slow
      end else if (left[p] != 5'h00) begin
        left[p] <= left[p] - 5'h01;
      end
    end
  end
endmodule : poerb_port_model

// File: tb/test_poerb_top.sv
// test_poerb_top: self-checking bench for the port manager register bank
// assumes: poerb_port_model answers function starts; short counts
`timescale 1ns/1ps
`include "poerb_cfg.svh"
module test_poerb_top;
  // ****************
  // signals
  // ****************
  localparam int POR_N = 8; // short power-on count keeps the run brief
  localparam int DISC_N = 16; // short discovery count
  localparam logic [1:0] REV = 2'h1; // arbitrary value
  localparam logic [1:0] IDC = 2'h3; // arbitrary value
  localparam logic [3:0] SUM = `POERB_REG_SUMMARY;
  localparam logic [3:0] CMN = `POERB_REG_COMMON;
  localparam logic [3:0] FN = `POERB_REG_FUNC;
  localparam logic [3:0] PW = `POERB_REG_PWR;
  localparam logic [3:0] ST = `POERB_REG_STATUS;
  localparam logic [3:0] TST = `POERB_REG_TEST;
  int error_cnt = 0;
  int samples_checked = 0;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic supply_ok = 1'h0; // supply starts invalid
  logic thermal_sense = 1'h0;
  logic [3:0] reg_sel = 4'h0;
  logic [1:0] port_sel = 2'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] lat = 4'h0; // model completion delay
  logic [3:0] port_disc_fail = 4'h0;
  logic [3:0][2:0] port_class = 12'h000;
  logic [3:0][2:0] port_fault = 12'h001; // must stay hidden while held
  logic [3:0] port_complete, func_start, disc_fault_dis, disconnect_mask;
  logic [3:0] port_off, adc_start, adc_abort;
  logic [7:0] reg_rdata;
  logic reg_rvalid, regs_rstn, thermal_shutdown, ports_kill, ac_hi_on, ac_lo_on;
  logic tsd_fault_dis, supply_range_fault_dis, disc_halt, disc_timer_dis;
  logic dc_disc_timer_dis, err_timer_dis;
  logic [3:0][3:0] func_code;
  logic [3:0][1:0] ilim_sel;
  // common and test outputs laid out as their register bits
  wire logic [7:0] cmn_obs = {2'h0, tsd_fault_dis, ac_hi_on, ac_lo_on,
    supply_range_fault_dis, ports_kill, 1'h0};
  wire logic [7:0] tst_obs = {1'h0, thermal_shutdown, disc_halt, disc_timer_dis,
    1'h0, dc_disc_timer_dis, err_timer_dis, 1'h0};

  poerb_top #(.POR_CYCLES(POR_N), .DISC_CYCLES(DISC_N), .CHIP_REV(REV), .CHIP_ID(IDC)) u_dut (
    .ref_clk, .resetn, .supply_ok, .thermal_sense, .reg_sel, .port_sel, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .port_complete, .port_disc_fail, .port_class,
    .port_fault, .regs_rstn, .thermal_shutdown, .ports_kill, .ac_hi_on, .ac_lo_on,
    .tsd_fault_dis, .supply_range_fault_dis, .disc_halt, .disc_timer_dis,
    .dc_disc_timer_dis, .err_timer_dis, .func_code, .func_start, .disc_fault_dis,
    .disconnect_mask, .port_off, .adc_start, .adc_abort, .ilim_sel);
  poerb_port_model u_model (.ref_clk, .func_start, .func_code, .lat, .port_complete);

  // ****************
  // tasks and tests
  // ****************
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  // one write; strobe held across exactly one rising edge
  task automatic wr(input logic [3:0] s, input logic [1:0] p, input logic [7:0] d);
    @(negedge ref_clk);
    reg_sel = s;
    port_sel = p;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge ref_clk);
    reg_wr = 1'h0;
  endtask : wr

  // one read, data judged in the cycle that rvalid stands
  task automatic rdc(input logic [3:0] s, input logic [1:0] p, input logic [7:0] e,
    input string w);
    @(negedge ref_clk);
    reg_sel = s;
    port_sel = p;
    reg_rd = 1'h1;
    @(negedge ref_clk);
    reg_rd = 1'h0;
    chk({7'h00, reg_rvalid}, 8'h01, "rvalid");
    chk(reg_rdata, e, w);
  endtask : rdc

  task automatic t_por;
    rdc(SUM, 2'h0, 8'h00, "held read");
    wr(CMN, 2'h0, 8'h10);
    chk(cmn_obs, 8'h00, "held write");
    wr(TST, 2'h0, 8'h08);
    idle(3);
    chk({7'h00, regs_rstn}, 8'h01, "forced");
    wr(TST, 2'h0, 8'h00);
    idle(3);
    chk({7'h00, regs_rstn}, 8'h00, "unforced");
    supply_ok = 1'h1;
    idle(POR_N);
    chk({7'h00, regs_rstn}, 8'h00, "timer running");
    idle(6);
    chk({7'h00, regs_rstn}, 8'h01, "timer done");
    $display("t_por done");
  endtask : t_por

  task automatic t_func;
    for (int c = 0; c < 16; c++) begin
      lat = c[3:0]; // prompt to slow answers
      wr(FN, 2'h1, {4'hc, c[3:0]}); // spare bits 7:6 set too
      chk({4'h0, func_code[1]}, {4'h0, c[3:0]}, "code");
      chk({4'h0, func_code[0]}, 8'h00, "other port");
      chk({4'h0, func_start}, (c < 13) ? 8'h02 : 8'h00, "start");
      chk({disc_fault_dis, disconnect_mask}, 8'h00, "spare");
      rdc(ST, 2'h1, 8'h00, "done cleared");
      idle(30); // wait out completion before the next code
      rdc(ST, 2'h1, (c < 13) ? 8'h40 : 8'h00, "done set");
    end
    wr(FN, 2'h1, 8'h35);
    chk({disc_fault_dis, disconnect_mask}, 8'h22, "limits masks");
    $display("t_func done");
  endtask : t_func

  task automatic t_ident;
    port_fault = {3'h4, 3'h0, 3'h2, 3'h0};
    rdc(SUM, 2'h0, {4'ha, REV, IDC}, "summary");
    port_disc_fail = 4'h4;
    port_class = {3'h0, 3'h3, 3'h0, 3'h0};
    for (int f = 0; f < 5; f++) begin
      port_fault[2] = f[2:0];
      rdc(ST, 2'h2, {1'h1, 1'h0, 3'h3, f[2:0]}, "status");
    end
    port_fault = 12'h000;
    port_disc_fail = 4'h0;
    port_class = 12'h000;
    $display("t_ident done");
  endtask : t_ident

  task automatic t_common;
    logic [7:0] v [5] = '{8'hfe, 8'h10, 8'h08, 8'h02, 8'h00};
    foreach (v[i]) begin
      wr(CMN, 2'h0, v[i]);
      chk(cmn_obs, v[i] & 8'h3e, "common");
    end
    rdc(CMN, 2'h0, 8'h00, "write only");
    $display("t_common done");
  endtask : t_common

  task automatic t_test;
    logic [7:0] v [7] = '{8'hff, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h00};
    foreach (v[i]) begin
      wr(TST, 2'h0, v[i]);
      idle(1);
      chk(tst_obs, v[i] & 8'h76, "test");
    end
    thermal_sense = 1'h1;
    idle(4);
    chk(tst_obs, 8'h40, "sensed heat");
    thermal_sense = 1'h0;
    idle(4);
    chk(tst_obs, 8'h00, "heat gone");
    $display("t_test done");
  endtask : t_test

  task automatic t_halt;
    lat = 4'h0;
    wr(TST, 2'h0, 8'h20);
    wr(FN, 2'h0, 8'h01);
    idle(30);
    rdc(ST, 2'h0, 8'h00, "halted");
    wr(TST, 2'h0, 8'h10);
    idle(30);
    rdc(ST, 2'h0, 8'h00, "timer off");
    wr(TST, 2'h0, 8'h00);
    idle(DISC_N - 4);
    rdc(ST, 2'h0, 8'h00, "still running");
    idle(8);
    rdc(ST, 2'h0, 8'h40, "disc done");
    $display("t_halt done");
  endtask : t_halt

  task automatic t_pwr;
    port_class[3] = 3'h1;
    wr(PW, 2'h3, 8'hff); // spare bits set too
    chk({4'h0, adc_start}, 8'h08, "adc go");
    chk({port_off, adc_abort}, 8'h88, "off abort");
    idle(1);
    chk({4'h0, adc_start}, 8'h00, "adc self clear");
    chk(ilim_sel, 8'h40, "class 1 limit");
    port_class[3] = 3'h2;
    idle(2);
    chk(ilim_sel, 8'h80, "class 2 limit");
    wr(PW, 2'h3, 8'h00);
    idle(1);
    chk(ilim_sel, 8'h00, "full limit");
    chk({port_off, adc_abort}, 8'h00, "cleared");
    $display("t_pwr done");
  endtask : t_pwr

  task automatic t_swrst;
    wr(CMN, 2'h0, 8'h1c);
    wr(TST, 2'h0, 8'h04);
    wr(FN, 2'h2, 8'h33);
    wr(CMN, 2'h0, 8'h01);
    chk({7'h00, regs_rstn}, 8'h00, "soft reset");
    idle(1);
    chk({ac_hi_on, ac_lo_on, dc_disc_timer_dis, 1'h0, func_code[2]}, 8'h00,
      "zeroed");
    idle(POR_N + 6);
    chk({7'h00, regs_rstn}, 8'h01, "released");
    chk(cmn_obs | tst_obs, 8'h00, "still zero");
    rdc(ST, 2'h2, 8'h00, "status reset");
    $display("t_swrst done");
  endtask : t_swrst

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // main sequence, about 800 cycles
  initial begin
    idle(10);
    resetn = 1'h1;
    t_por;
    t_func;
    t_ident;
    t_common;
    t_test;
    t_halt;
    t_pwr;
    t_swrst;
    end_sim;
  end

  // watchdog: several times the expected run
  initial begin
    #40000;
    error_cnt++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim;
  end
endmodule : test_poerb_top
